// File: crf_pkg.sv
/*
  Package for the core register file: register numbers, widths, reset
  values and enumerations shared by the register file and its helper.
  Assumes nothing beyond a SystemVerilog-2012 compiler.
*/
package crf_pkg;
  // ****************************************************************
  // Sizes and register numbers
  // ****************************************************************
  localparam int          DATA_W        = 32;
  localparam int          IDX_W         = 4;
  localparam int          NUM_GPR       = 13;
  localparam logic [3:0]  LOW_LAST      = 4'h7;
  localparam logic [3:0]  HIGH_LAST     = 4'hC;
  localparam logic [3:0]  SP_IDX        = 4'hD;
  localparam logic [3:0]  LINK_IDX      = 4'hE;
  localparam logic [3:0]  PC_IDX        = 4'hF;
  localparam logic [31:0] GPR_RST       = 32'h0000_0000;
  localparam logic [31:0] SP_RST        = 32'h0000_0000;
  localparam logic [31:0] PC_RST        = 32'h0000_0000;
  localparam logic [31:0] RET_OFFSET    = 32'h0000_0004;
  localparam logic        STACK_SEL_RST = 1'b0;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [0:0] {
    CRF_THREAD  = 1'b0,
    CRF_HANDLER = 1'b1
  } crf_mode_t;

  typedef enum logic [0:0] {
    CRF_ENC_SHORT = 1'b0,
    CRF_ENC_LONG  = 1'b1
  } crf_enc_t;
endpackage : crf_pkg

// File: crf_sel_if.sv
/*
  Interface carrying the access checks between the register file and
  its selector helper. Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface crf_sel_if;
  logic [3:0] idx;
  logic       enc_long;
  logic       handler;
  logic       stack_sel;
  logic       legal;
  logic       use_process;
  logic       is_sp;

  modport top    (output idx, output enc_long, output handler,
                  output stack_sel, input legal, input use_process,
                  input is_sp);
  modport helper (input idx, input enc_long, input handler,
                  input stack_sel, output legal, output use_process,
                  output is_sp);
endinterface : crf_sel_if

// File: crf_sel.sv
/*
  Register selector: decides whether an index may be reached by the
  given encoding and which banked stack pointer stands behind r13.
  Assumes purely combinational use within the core clock domain.
*/
`timescale 1ns/1ps
module crf_sel (
  crf_sel_if.helper s
);
  always_comb begin
    // Short encodings reach only r0..r7; long reach everything
    s.legal = (s.idx <= crf_pkg::LOW_LAST) || s.enc_long;
    s.is_sp = (s.idx == crf_pkg::SP_IDX);
    // Handler mode always uses the main copy
    s.use_process = s.stack_sel && !s.handler;
  end
endmodule : crf_sel

// File: crf_core_regfile.sv
/*
  Core register file of the processor: thirteen general registers
  r0..r12, split into a low set r0..r7 and a high set r8..r12, the
  banked stack pointer r13, the link register r14 and the program
  counter r15, behind one read port and one write port.
  Assumes the decode/execute pipeline on mclk drives every request
  input for one clock and treats rd_illegal or wr_illegal as a refusal
  of the operand it named. Only 32-bit-form operands may name r8..r15;
  a refused write is dropped. Read data is registered, so a write is
  seen by a read issued on the clock after the write edge, and a
  branch target on pc_load overrides a register write to r15.
*/
`timescale 1ns/1ps
module crf_core_regfile #(
  parameter int DATA_W = crf_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // Read port
  input  wire logic [3:0]        rd_idx,
  input  wire logic              rd_long,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   rd_illegal,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [3:0]        wr_idx,
  input  wire logic              wr_long,
  input  wire logic [DATA_W-1:0] wr_data,
  output logic                   wr_illegal,
  // Processor mode and stack select
  input  wire logic              handler_mode,
  input  wire logic              stack_sel_wr,
  input  wire logic              stack_sel_val,
  // Program flow
  input  wire logic              link_branch,
  input  wire logic              pc_load,
  input  wire logic [DATA_W-1:0] pc_next,
  output logic      [DATA_W-1:0] pc,
  output logic                   stack_sel
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [crf_pkg::NUM_GPR-1:0][DATA_W-1:0] gpr;
    logic [DATA_W-1:0] main_stack_pointer;
    logic [DATA_W-1:0] process_stack_pointer;
    logic [DATA_W-1:0] link;
    logic [DATA_W-1:0] pc;
    logic              stack_sel;
    // Read results are registered so every output is a flip-flop
    logic [DATA_W-1:0] rd_data;
    logic              rd_illegal;
    logic              wr_illegal;
  } crf_state_t;

  crf_state_t st;
  crf_state_t next_st;

  // ****************************************************************
  // Access checks
  // ****************************************************************
  // Read and write operands are checked by separate selectors
  crf_sel_if rs ();
  crf_sel_if ws ();

  crf_sel u_rd_sel (.s(rs.helper));
  crf_sel u_wr_sel (.s(ws.helper));

  assign rs.idx       = rd_idx;
  assign rs.enc_long  = rd_long;
  assign rs.handler   = handler_mode;
  assign rs.stack_sel = st.stack_sel;
  assign ws.idx       = wr_idx;
  assign ws.enc_long  = wr_long;
  assign ws.handler   = handler_mode;
  assign ws.stack_sel = st.stack_sel;

  // ****************************************************************
  // Operand decode
  // ****************************************************************
  // One hit line per general register; r13..r15 decode apart
  wire logic [crf_pkg::NUM_GPR-1:0]             gpr_hit;
  wire logic [crf_pkg::NUM_GPR-1:0][DATA_W-1:0] gpr_next;
  logic                                          wr_ok;
  logic                                          sp_hit;
  logic                                          link_hit;
  logic                                          pc_hit;
  logic                                          rd_gpr;
  logic                                          rd_link;
  logic [DATA_W-1:0]                             sp_view;

  // Write hits are already qualified by wr_en and the access check
  assign wr_ok    = wr_en && ws.legal;
  assign sp_hit   = wr_ok && ws.is_sp;
  assign link_hit = wr_ok && (wr_idx == crf_pkg::LINK_IDX);
  assign pc_hit   = wr_ok && (wr_idx == crf_pkg::PC_IDX);
  assign rd_gpr   = (rd_idx <= crf_pkg::HIGH_LAST);
  assign rd_link  = (rd_idx == crf_pkg::LINK_IDX);

  // Read side sees the copy chosen by mode and select bit
  assign sp_view = rs.use_process ? st.process_stack_pointer
                                  : st.main_stack_pointer;

  // Unselected registers keep their value
  for (genvar g = 0; g < crf_pkg::NUM_GPR; g++) begin : g_gpr
    assign gpr_hit[g]  = wr_ok && (wr_idx == 4'(g));
    assign gpr_next[g] = gpr_hit[g] ? wr_data : st.gpr[g];
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;

    // ****************************************************************
    // Read port
    // ****************************************************************
    // A short-form high index returns zero and is flagged
    // Read data is registered; a write in the same cycle is not bypassed
    next_st.rd_illegal = !rs.legal;
    next_st.rd_data    = '0;
    if (rs.legal) begin
      if (rd_gpr) begin
        next_st.rd_data = st.gpr[rd_idx];
      end else if (rs.is_sp) begin
        next_st.rd_data = sp_view;
      end else if (rd_link) begin
        next_st.rd_data = st.link;
      end else begin
        next_st.rd_data = st.pc;
      end
    end

    // ****************************************************************
    // Write port
    // ****************************************************************
    // A refused write is dropped, not remapped to a low register
    next_st.wr_illegal = wr_en && !ws.legal;
    next_st.gpr        = gpr_next;
    // Only the selected stack copy changes; the other holds
    if (sp_hit) begin
      if (ws.use_process) begin
        next_st.process_stack_pointer = wr_data;
      end else begin
        next_st.main_stack_pointer = wr_data;
      end
    end
    if (link_hit) begin
      next_st.link = wr_data;
    end
    // Register r15 takes the long form only, like any high register
    if (pc_hit) begin
      next_st.pc = wr_data;
    end

    // ****************************************************************
    // Link capture and program counter
    // ****************************************************************
    // Link capture wins over a plain r14 write in the same cycle
    // Return address is pc plus the fixed return offset
    if (link_branch) begin
      next_st.link = st.pc + DATA_W'(crf_pkg::RET_OFFSET);
    end
    // A branch target from the pipeline beats a write to r15
    if (pc_load) begin
      next_st.pc = pc_next;
    end

    // ****************************************************************
    // Thread-mode stack select
    // ****************************************************************
    // Handler mode ignores the bit, but it is still stored
    if (stack_sel_wr) begin
      next_st.stack_sel = stack_sel_val;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // Synchronous reset; registers and stack select load package constants, read data and both refusal flags load zero
      st.gpr <= {crf_pkg::NUM_GPR{DATA_W'(crf_pkg::GPR_RST)}};
      st.main_stack_pointer    <= DATA_W'(crf_pkg::SP_RST);
      st.process_stack_pointer <= DATA_W'(crf_pkg::SP_RST);
      st.link                  <= DATA_W'(crf_pkg::GPR_RST);
      st.pc                    <= DATA_W'(crf_pkg::PC_RST);
      st.stack_sel             <= crf_pkg::STACK_SEL_RST;
      st.rd_data               <= '0;
      st.rd_illegal            <= 1'h0;
      st.wr_illegal            <= 1'h0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output is a state flip-flop, never decode logic
  assign rd_data    = st.rd_data;
  assign rd_illegal = st.rd_illegal;
  assign wr_illegal = st.wr_illegal;
  assign pc         = st.pc;
  assign stack_sel  = st.stack_sel;
endmodule : crf_core_regfile

// File: crf_core_regfile_props.sv
/* Checker on the register file ports.
   Assumes one clock, mclk, and sync reset sys_rst. */
`timescale 1ns/1ps
module crf_core_regfile_props (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [3:0]  rd_idx,
  input wire logic        rd_long,
  input wire logic [31:0] rd_data,
  input wire logic        rd_illegal,
  input wire logic        wr_en,
  input wire logic [3:0]  wr_idx,
  input wire logic        wr_long,
  input wire logic [31:0] wr_data,
  input wire logic        wr_illegal,
  input wire logic        handler_mode,
  input wire logic        stack_sel_wr,
  input wire logic        stack_sel_val,
  input wire logic        link_branch,
  input wire logic        pc_load,
  input wire logic [31:0] pc_next,
  input wire logic [31:0] pc,
  input wire logic        stack_sel
);
  // ****************************
  // Port relations
  // ****************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_RD_REFUSE: assert property (
    !rd_long && rd_idx > 4'h7 |=> rd_illegal && rd_data == 32'h0)
    else $error("short read of high reg not refused");
  AST_WR_REFUSE: assert property (
    wr_en && !wr_long && wr_idx > 4'h7 |=> wr_illegal)
    else $error("short write of high reg not refused");
  AST_LOW_OPEN: assert property (rd_idx <= 4'h7 |=> !rd_illegal)
    else $error("low read refused");
  AST_LONG_OPEN: assert property (rd_long |=> !rd_illegal)
    else $error("long read refused");
  AST_SEL_LOAD: assert property (
    stack_sel_wr |=> stack_sel == $past(stack_sel_val))
    else $error("stack select not loaded");
  AST_SEL_HOLD: assert property (
    !stack_sel_wr |=> $stable(stack_sel))
    else $error("stack select moved");
  AST_PC_LOAD: assert property (pc_load |=> pc == $past(pc_next))
    else $error("pc not loaded");
  AST_LINK: assert property (
    link_branch && !pc_load ##1 !link_branch && !(wr_en && wr_idx == 4'hE)
    ##1 rd_idx == 4'hE && rd_long |=> rd_data == $past(pc, 3) + 32'h4)
    else $error("link value wrong");
endmodule : crf_core_regfile_props
bind crf_core_regfile crf_core_regfile_props u_props (.*);

// File: crf_pipe_model.sv
/* Decode/execute side model: issues requests at the falling edge.
   Assumes the register file samples on the rising mclk edge. */
`timescale 1ns/1ps
module crf_pipe_model (
  input  wire logic   mclk,
  output logic [3:0]  rd_idx,
  output logic        rd_long,
  output logic        wr_en,
  output logic [3:0]  wr_idx,
  output logic        wr_long,
  output logic [31:0] wr_data,
  output logic        handler_mode,
  output logic        stack_sel_wr,
  output logic        stack_sel_val,
  output logic        link_branch,
  output logic        pc_load,
  output logic [31:0] pc_next
);
  initial begin
    {rd_long, wr_en, wr_long, handler_mode, stack_sel_wr} = '0;
    {stack_sel_val, link_branch, pc_load, rd_idx, wr_idx} = '0;
    {wr_data, pc_next} = '0;
  end
  task automatic wr(input logic [3:0] i, input logic l, input logic [31:0] d);
    @(negedge mclk);
    {wr_en, wr_idx, wr_long, wr_data} = {1'b1, i, l, d};
    @(negedge mclk);
    wr_en = 1'b0;
    wr_data = ~d; // Stale data must not look valid
  endtask : wr
  task automatic rd(input logic [3:0] i, input logic l);
    @(negedge mclk);
    {rd_idx, rd_long} = {i, l};
    @(negedge mclk);
  endtask : rd
  task automatic mode(input logic hm, input logic sel);
    @(negedge mclk);
    {handler_mode, stack_sel_wr, stack_sel_val} = {hm, 1'b1, sel};
    @(negedge mclk);
    stack_sel_wr = 1'b0;
  endtask : mode
  task automatic jump(input logic [31:0] p);
    @(negedge mclk);
    {pc_load, pc_next} = {1'b1, p};
    @(negedge mclk);
    {pc_load, pc_next, link_branch} = {1'b0, ~p, 1'b1};
    @(negedge mclk);
    link_branch = 1'b0;
  endtask : jump
endmodule : crf_pipe_model

// File: testbench.sv
/* Self-checking bench for the core register file.
   Assumes crf_pipe_model drives every request input. */
`timescale 1ns/1ps
module testbench;
  logic        mclk, sys_rst, rd_long, rd_illegal, wr_en, wr_long;
  logic        wr_illegal, handler_mode, stack_sel_wr, stack_sel_val;
  logic        link_branch, pc_load, stack_sel;
  logic [3:0]  rd_idx, wr_idx;
  logic [31:0] rd_data, wr_data, pc_next, pc;
  int          fail_count = 0;
  int          num_checks = 0;
  crf_core_regfile uut (.*);
  crf_pipe_model pipe (.*);
  // ****************************
  // Checks and scenarios
  // ****************************
  task automatic chk(input logic [31:0] g, e, input logic gi, ei);
    num_checks++;
    if (g !== e || gi !== ei) begin
      fail_count++;
      $display("[ERR] %0t got %h/%b want %h/%b", $time, g, gi, e, ei);
    end
  endtask : chk
  task automatic rc(input logic [3:0] i, input logic l, input logic [31:0] e,
                    input logic ei);
    pipe.rd(i, l);
    chk(rd_data, e, rd_illegal, ei);
  endtask : rc
  task automatic t_sets;
    for (int i = 0; i < 13; i++) begin
      pipe.wr(4'(i), 1'b1, 32'hA5A50000 + i);
    end
    for (int i = 0; i < 13; i++) begin
      rc(4'(i), 1'b1, 32'hA5A50000 + i, 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      rc(4'(i), 1'b0, 32'hA5A50000 + i, 1'b0);
    end
    for (int i = 8; i < 16; i++) begin
      rc(4'(i), 1'b0, 32'h0, 1'b1);
    end
    pipe.wr(4'h8, 1'b0, 32'h0BAD0BAD);
    chk(32'h0, 32'h0, wr_illegal, 1'b1);
    rc(4'h8, 1'b1, 32'hA5A50008, 1'b0);
  endtask : t_sets
  task automatic t_stack;
    pipe.mode(1'b1, 1'b0);
    pipe.wr(4'hD, 1'b1, 32'h00001000);
    pipe.mode(1'b0, 1'b1);
    pipe.wr(4'hD, 1'b1, 32'h00002000);
    rc(4'hD, 1'b1, 32'h00002000, 1'b0);
    pipe.mode(1'b1, 1'b1);
    rc(4'hD, 1'b1, 32'h00001000, 1'b0);
    pipe.mode(1'b0, 1'b0);
    rc(4'hD, 1'b1, 32'h00001000, 1'b0);
    pipe.mode(1'b0, 1'b1);
    chk(32'h0, 32'h0, stack_sel, 1'b1);
    rc(4'hD, 1'b1, 32'h00002000, 1'b0);
  endtask : t_stack
  task automatic t_link;
    pipe.jump(32'h00000100);
    chk(pc, 32'h00000100, 1'b0, 1'b0);
    rc(4'hE, 1'b1, 32'h00000104, 1'b0);
    rc(4'hF, 1'b1, 32'h00000100, 1'b0);
    pipe.wr(4'hF, 1'b1, 32'h00000200);
    chk(pc, 32'h00000200, 1'b0, 1'b0);
    pipe.wr(4'hE, 1'b1, 32'h55550000);
    rc(4'hE, 1'b1, 32'h55550000, 1'b0);
  endtask : t_link
  task automatic t_reset;
    @(negedge mclk) sys_rst = 1'b1;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    chk(pc, crf_pkg::PC_RST, 1'b0, 1'b0);
    chk(32'h0, 32'h0, stack_sel, crf_pkg::STACK_SEL_RST);
    rc(4'h0, 1'b1, crf_pkg::GPR_RST, 1'b0);
    rc(4'hD, 1'b1, crf_pkg::SP_RST, 1'b0);
    rc(4'hE, 1'b1, crf_pkg::GPR_RST, 1'b0);
  endtask : t_reset
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    #50000;
    fail_count++;
    summarize();
  end
  initial begin
    sys_rst = 1'b1;
    repeat (8) @(posedge mclk);
    @(negedge mclk) sys_rst = 1'b0;
    chk(pc, 32'h0, stack_sel, 1'b0);
    t_sets();
    t_stack();
    t_link();
    t_reset();
    summarize();
  end
endmodule : testbench
